// >>> ustwsd_dev.sv
// universal serial unit end: shifter, 4-bit counter and start detector
//
// How it works
// [RQ1] two-wire signalling, no slew limit, no filter
// [RQ2] master clocks; slave stretches; both shift automatically
// [RQ3] software selects negative-edge shifting in two-wire
// [RQ4] master checks scl really rose
// [RQ5] every scl edge increments counter; overflow ends transfer
// [RQ6] master makes start by pulling sda low
// [RQ7] start condition sets start-detect flag, may interrupt
// [RQ8] after start, first scl fall held low
// [RQ9] slave clears flag, resets counter, releasing scl
// [RQ10] slave samples sda on scl rising edge
// [RQ11] eight bits overflow counter, scl forced low
// [RQ12] unaddressed slave releases scl, awaits start
// [RQ13] addressed slave acks, preloads counter with 14
// [RQ14] direction bit one: slave drives sda
// [RQ15] bytes continue same direction until stop/start
// [RQ16] no ack ends receive; master ends read
// [RQ17] sda delayed 50 to 300 ns for detector
// [RQ18] start detection only in two-wire mode
// [RQ19] other modes: scl edge sets flag when selected
// [RQ20] detector needs no running software, wakes processor
// [RQ21] counter stands alone; pin clock counts both edges
// [RQ22] counter at fifteen gives edge interrupt
// [RQ23] counter wraps, sets sticky overflow flag
`default_nettype none
module ustwsd_dev (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  ustwsd_if.dev link,
  // mode and clock selection
  input wire logic [1:0] wire_mode_i,
  input wire logic [1:0] clk_src_i,
  input wire logic clk_strobe_sel_i,
  input wire logic soft_strobe_i,
  // loads and flag clears
  input wire logic data_load_i,
  input wire logic [7:0] data_i,
  input wire logic cnt_load_i,
  input wire logic [3:0] cnt_i,
  input wire logic start_clr_i,
  input wire logic ovf_clr_i,
  input wire logic start_ie_i,
  input wire logic ovf_ie_i,
  // data pin port bits
  input wire logic data_pin_direction_bit_i,
  input wire logic data_pin_output_value_i,
  // status
  output logic [7:0] data_o,
  output logic [3:0] cnt_o,
  output logic start_detect_flag_o,
  output logic ovf_flag_o,
  output logic irq_o,
  output logic wake_o
);
  import ustwsd_pkg::*;

  // ==========================================================
  // line synchronisers and sda delay line
  logic scl_s1;
  logic scl_s2;
  logic scl_q;
  logic sda_s1;
  logic sda_s2;
  logic [SDA_DLY_CYC:0] sda_dly;
  logic [SDA_DLY_CYC:0] next_sda_dly;

  // sda is held back a few clocks longer than scl so that a falling sda
  // is always judged against a settled scl level
  always_comb begin
    next_sda_dly = {sda_dly[SDA_DLY_CYC-1:0], sda_s2}; // RQ17
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_dly <= '1;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_dly <= next_sda_dly;
    end
  end

  // ==========================================================
  // shifter, counter, flags and stretch control
  logic [7:0] data;
  logic [3:0] cnt;
  logic start_flag;
  logic ovf_flag;
  logic seen_fall;
  logic in_bit;
  logic [7:0] next_data;
  logic [3:0] next_cnt;
  logic next_start_flag;
  logic next_ovf_flag;
  logic next_seen_fall;
  logic next_in_bit;
  logic two_wire;
  logic ext_clk;
  logic scl_rise;
  logic scl_fall;
  logic scl_edge;
  logic start_cond;
  logic alt_start;
  logic count_tick;
  logic shift_tick;
  logic shift_bit;

  // pin edges count both ways; the shift edge follows the clock source
  always_comb begin
    two_wire = (wire_mode_i == MODE_TWO);
    ext_clk = clk_src_i[1];
    scl_rise = scl_s2 & ~scl_q;
    scl_fall = ~scl_s2 & scl_q;
    scl_edge = scl_s2 ^ scl_q;
    // sda falling while scl high, sda seen through the delay line
    start_cond = two_wire & scl_s2 & sda_dly[SDA_DLY_CYC] & ~sda_dly[SDA_DLY_CYC-1]; // RQ18
    alt_start = ~two_wire & ext_clk & ~clk_strobe_sel_i & scl_edge; // RQ19
    count_tick = ext_clk ? scl_edge : soft_strobe_i; // RQ5 RQ21
    if (!ext_clk) begin
      shift_tick = soft_strobe_i;
    end else if (clk_src_i == CS_EXT_POS) begin
      shift_tick = scl_rise;
    end else begin
      shift_tick = scl_fall; // RQ3
    end
    shift_bit = (clk_src_i == CS_EXT_NEG) ? in_bit : sda_s2;
    next_in_bit = scl_rise ? sda_s2 : in_bit; // RQ10
    next_data = data;
    if (data_load_i) begin
      next_data = data_i;
    end else if (shift_tick) begin
      next_data = {data[6:0], shift_bit}; // RQ10
    end
    next_cnt = cnt;
    // a count tick at CNT_MAX wins over a clear in the same cycle
    next_ovf_flag = ovf_flag & ~ovf_clr_i;
    if (cnt_load_i) begin
      next_cnt = cnt_i; // RQ13 RQ22
    end else if (count_tick) begin
      next_cnt = cnt + 4'h1; // RQ15 RQ23
      if (cnt == CNT_MAX) begin
        next_ovf_flag = 1'b1; // RQ11 RQ22 RQ23
      end
    end
    next_start_flag = start_flag & ~start_clr_i;
    if (start_cond | alt_start) begin
      next_start_flag = 1'b1; // RQ7 RQ19
    end
    // stretch arms only on the first scl fall after a start, so the
    // master can still finish the start before the line is held
    next_seen_fall = seen_fall;
    if (start_cond) begin
      next_seen_fall = 1'b0;
    end else if (scl_fall & start_flag) begin
      next_seen_fall = 1'b1; // RQ8
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data <= DATA_RST;
      cnt <= 4'h0;
      start_flag <= 1'b0;
      ovf_flag <= 1'b0;
      seen_fall <= 1'b0;
      in_bit <= 1'b1;
    end else begin
      data <= next_data;
      cnt <= next_cnt;
      start_flag <= next_start_flag;
      ovf_flag <= next_ovf_flag;
      seen_fall <= next_seen_fall;
      in_bit <= next_in_bit;
    end
  end

  // ==========================================================
  // open-drain pin drive, status and interrupt
  // stretch ends when software clears the start flag and the overflow flag
  // three-wire and off modes leave both pins released
  assign link.dev_scl_o = 1'b0;
  assign link.dev_scl_oe = two_wire & ((start_flag & seen_fall) | ovf_flag); // RQ2 RQ8 RQ9 RQ11
  assign link.dev_sda_o = 1'b0;
  // direct drive, no slew shaping; low when shifter msb or port bit is zero
  assign link.dev_sda_oe = two_wire & data_pin_direction_bit_i
                           & (~data[7] | ~data_pin_output_value_i); // RQ1 RQ14 RQ16
  assign data_o = data;
  assign cnt_o = cnt;
  assign start_detect_flag_o = start_flag;
  assign ovf_flag_o = ovf_flag;
  assign irq_o = (start_flag & start_ie_i) | (ovf_flag & ovf_ie_i); // RQ7 RQ22
  // start flag doubles as a wake request needing no software activity
  assign wake_o = start_flag; // RQ20
endmodule : ustwsd_dev
`default_nettype wire

// >>> ustwsd_pkg.sv
// constants shared by both ends of the two-wire serial link
`default_nettype none
package ustwsd_pkg;
  // ==========================================================
  // wire modes and shift clock sources
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [1:0] CS_EXT_NEG = 2'h3;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [7:0] DATA_RST = 8'hff;
  // ==========================================================
  // start detector sda delay
  localparam int CLK_PERIOD_NS = 20;
  localparam int SDA_DLY_MIN_NS = 50;
  localparam int SDA_DLY_MAX_NS = 300;
  localparam int SDA_DLY_CYC = (SDA_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SDA_DLY_MAX_CYC = SDA_DLY_MAX_NS / CLK_PERIOD_NS;
  // ==========================================================
  // controller register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_CNT = 4'hc;
  localparam int CTRL_SCL_REL = 0;
  localparam int CTRL_SDA_REL = 1;
  localparam int CTRL_SDA_DIR = 2;
  localparam logic [2:0] CTRL_RST = 3'h3;
  localparam int STAT_SCL = 0;
  localparam int STAT_SDA = 1;
  localparam int STAT_SCL_STUCK = 2;
  localparam int STAT_CNT_LSB = 4;
  localparam int STAT_OVF = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : ustwsd_pkg
`default_nettype wire

// >>> ustwsd_if.sv
// open-drain scl and sda link between the unit and the controller
`default_nettype none
interface ustwsd_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  // a line is low while either end drives a low, else pulled high
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
  modport dev(input scl, input sda, output dev_scl_o, output dev_scl_oe,
              output dev_sda_o, output dev_sda_oe);
  modport host(input scl, input sda, output host_scl_o, output host_scl_oe,
               output host_sda_o, output host_sda_oe);
endinterface : ustwsd_if
`default_nettype wire

// >>> ustwsd_host.sv
// bus controller end: software-clocked master with an ahb-lite register port
`default_nettype none
module ustwsd_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // link
  ustwsd_if.host link
);
  import ustwsd_pkg::*;

  // ==========================================================
  // line synchronisers
  logic scl_s1;
  logic scl_s2;
  logic scl_q;
  logic sda_s1;
  logic sda_s2;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  // ==========================================================
  // registers, shifter and bus slave
  logic [2:0] ctrl;
  logic [7:0] data;
  logic [3:0] cnt;
  logic ovf_flag;
  logic in_bit;
  logic dp_wr;
  logic [3:0] dp_addr;
  logic [31:0] rdata;
  logic [2:0] next_ctrl;
  logic [7:0] next_data;
  logic [3:0] next_cnt;
  logic next_ovf_flag;
  logic next_in_bit;
  logic next_dp_wr;
  logic [3:0] next_dp_addr;
  logic [31:0] next_rdata;
  logic scl_rise;
  logic scl_fall;
  logic ap_valid;
  logic in_map;
  logic [31:0] stat;

  always_comb begin
    scl_rise = scl_s2 & ~scl_q;
    scl_fall = ~scl_s2 & scl_q;
    ap_valid = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
    // only the first four words are mapped; anything above reads zero
    in_map = (haddr_i[31:4] == 28'h0);
    stat = 32'h0;
    stat[STAT_SCL] = scl_s2;
    stat[STAT_SDA] = sda_s2;
    stat[STAT_SCL_STUCK] = ctrl[CTRL_SCL_REL] & ~scl_s2; // RQ4
    stat[STAT_CNT_LSB +: 4] = cnt;
    stat[STAT_OVF] = ovf_flag;
    next_dp_wr = ap_valid & hwrite_i & in_map;
    next_dp_addr = ap_valid ? haddr_i[3:0] : dp_addr;
    next_rdata = rdata;
    if (ap_valid & ~hwrite_i) begin
      case (haddr_i[3:0])
        REG_CTRL: next_rdata = {29'h0, ctrl};
        REG_DATA: next_rdata = {24'h0, data};
        REG_STAT: next_rdata = stat;
        REG_CNT: next_rdata = {28'h0, cnt};
        default: next_rdata = 32'h0;
      endcase
      if (!in_map) begin
        next_rdata = 32'h0;
      end
    end
    next_in_bit = scl_rise ? sda_s2 : in_bit;
    next_ctrl = ctrl;
    next_data = data;
    next_cnt = cnt;
    next_ovf_flag = ovf_flag;
    if (scl_fall) begin
      next_data = {data[6:0], in_bit}; // RQ2 RQ3
    end
    if (scl_rise | scl_fall) begin
      next_cnt = cnt + 4'h1; // RQ5
    end
    if (dp_wr) begin
      case (dp_addr)
        REG_CTRL: next_ctrl = hwdata_i[2:0]; // RQ2 RQ16
        REG_DATA: next_data = hwdata_i[7:0]; // RQ6
        REG_STAT: next_ovf_flag = ovf_flag & ~hwdata_i[STAT_OVF];
        REG_CNT: next_cnt = hwdata_i[3:0];
        default: next_ctrl = ctrl;
      endcase
    end
    if ((scl_rise | scl_fall) & (cnt == CNT_MAX)) begin
      next_ovf_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RST;
      data <= DATA_RST;
      cnt <= 4'h0;
      ovf_flag <= 1'b0;
      in_bit <= 1'b1;
      dp_wr <= 1'b0;
      dp_addr <= 4'h0;
      rdata <= 32'h0;
    end else begin
      ctrl <= next_ctrl;
      data <= next_data;
      cnt <= next_cnt;
      ovf_flag <= next_ovf_flag;
      in_bit <= next_in_bit;
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // outputs
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = ~ctrl[CTRL_SCL_REL]; // RQ2
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = ctrl[CTRL_SDA_DIR] & (~ctrl[CTRL_SDA_REL] | ~data[7]); // RQ6 RQ14
endmodule : ustwsd_host
`default_nettype wire

// >>> ustwsd_chk.sv
// assertions on the two-wire link between both ends
`default_nettype none
module ustwsd_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  // unit mode and flag
  input wire logic [1:0] wire_mode_i,
  input wire logic start_detect_flag_o
);
  import ustwsd_pkg::*;
  // ==========================================================
  // link properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence start_s;
    wire_mode_i == MODE_TWO && scl && $fell(sda);
  endsequence
  sequence held_s;
    start_s ##1 scl [*8] ##[1:40] $fell(scl);
  endsequence
  a_scl_drain: assert property (!dev_scl_o && !host_scl_o)
    else $error("scl driven high");
  a_sda_drain: assert property (!dev_sda_o && !host_sda_o)
    else $error("sda driven high");
  a_reset_free: assert property ($rose(rst_n_i) |-> !dev_scl_oe && !dev_sda_oe &&
    !host_scl_oe && !host_sda_oe) else $error("line held after reset");
  a_start_flag: assert property (start_s |-> ##[1:10] start_detect_flag_o)
    else $error("start not flagged");
  a_start_stretch: assert property (held_s |-> ##[1:8] dev_scl_oe)
    else $error("scl not held after start");
  a_stretch_hold: assert property ($rose(dev_scl_oe) |=> dev_scl_oe [*4])
    else $error("stretch dropped early");
  a_off_quiet: assert property ((wire_mode_i != MODE_TWO) [*2] |->
    !dev_scl_oe && !dev_sda_oe) else $error("pins driven outside two-wire");
  a_sda_turn: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("sda changed with scl high");
endmodule : ustwsd_chk
`default_nettype wire

// >>> ustwsd_test.sv
// self-checking bench joining both link ends
`default_nettype none
module ustwsd_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ustwsd_pkg::*;
  logic clk_i = 0;
  logic rst_n_i = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic hready;
  logic hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] mode = MODE_TWO;
  logic [1:0] src = CS_EXT_NEG;
  logic strb = 0, dload = 0, cload = 0, sclr = 0, oclr = 0, oie = 0, dir = 0;
  logic sie = 0, ssel = 0;
  logic [7:0] din = 0, dout;
  logic [3:0] cin = 0, cnt;
  logic sflag, oflag, irq, wake;
  int bad_count = 0, compares = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  ustwsd_if link ();
  ustwsd_dev i_ustwsd_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link), .wire_mode_i(mode),
    .clk_src_i(src), .clk_strobe_sel_i(ssel), .soft_strobe_i(strb), .data_load_i(dload),
    .data_i(din), .cnt_load_i(cload), .cnt_i(cin), .start_clr_i(sclr), .ovf_clr_i(oclr),
    .start_ie_i(sie), .ovf_ie_i(oie), .data_pin_direction_bit_i(dir),
    .data_pin_output_value_i(1'b1), .data_o(dout), .cnt_o(cnt),
    .start_detect_flag_o(sflag), .ovf_flag_o(oflag), .irq_o(irq), .wake_o(wake));
  ustwsd_host i_ustwsd_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .link(link));
  ustwsd_chk i_ustwsd_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl(link.scl), .sda(link.sda),
    .dev_scl_o(link.dev_scl_o), .dev_scl_oe(link.dev_scl_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .host_scl_o(link.host_scl_o),
    .host_scl_oe(link.host_scl_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .wire_mode_i(mode), .start_detect_flag_o(sflag));
  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // each line level is kept well over four clocks
  task automatic ctl(input logic [2:0] v);
    ahb(1'b1, 8'(REG_CTRL), {29'h0, v});
    repeat (8) @(posedge clk_i);
  endtask : ctl
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : do_reset
  // ==========================================================
  // scenarios
  task automatic t_regs();
    ahb(1'b0, 8'(REG_CTRL), 0);
    chk("ctrl", rd, 32'h3);
    ahb(1'b0, 8'(REG_DATA), 0);
    chk("data", rd, 32'hff);
    ahb(1'b0, 8'(REG_STAT), 0);
    chk("stat", rd, 32'h3);
    ahb(1'b1, 8'h10, 32'hffffffff);
    ahb(1'b0, 8'h10, 0);
    chk("unmapped", rd, 32'h0);
    chk("dev data", dout, 32'hff);
  endtask : t_regs
  task automatic t_off();
    mode <= MODE_OFF;
    ctl(3'b101);
    chk("no start off", sflag, 0);
    ctl(3'b011);
    mode <= MODE_TWO;
  endtask : t_off
  task automatic t_xfer();
    sie <= 1'b1;
    ctl(3'b101);
    chk("start flag", sflag, 1);
    chk("start irq", irq, 1);
    chk("wake", wake, 1);
    ctl(3'b100);
    chk("start hold", link.dev_scl_oe, 1);
    ahb(1'b1, 8'(REG_DATA), 32'h5a);
    ctl(3'b111);
    ahb(1'b0, 8'(REG_STAT), 0);
    chk("scl stuck", rd[2:0], 32'h4);
    sclr <= 1'b1;
    cload <= 1'b1;
    cin <= 4'h0;
    @(posedge clk_i);
    sclr <= 1'b0;
    cload <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("released", link.scl, 1);
    repeat (7) begin
      ctl(3'b110);
      ctl(3'b111);
    end
    ctl(3'b110);
    chk("address", dout, 32'h5a);
    chk("ovf", oflag, 1);
    chk("ovf hold", link.dev_scl_oe, 1);
    chk("wrap", cnt, 0);
    ctl(3'b010);
    din <= 8'h00;
    dload <= 1'b1;
    cin <= 4'he;
    cload <= 1'b1;
    oclr <= 1'b1;
    dir <= 1'b1;
    @(posedge clk_i);
    dload <= 1'b0;
    cload <= 1'b0;
    oclr <= 1'b0;
    ctl(3'b011);
    chk("ack low", link.sda, 0);
    chk("count", cnt, 32'hf);
    ctl(3'b010);
    chk("ack ovf", oflag, 1);
    chk("ack hold", link.dev_scl_oe, 1);
    oclr <= 1'b1;
    dir <= 1'b0;
    @(posedge clk_i);
    oclr <= 1'b0;
    ctl(3'b011);
    chk("idle scl", link.scl, 1);
    chk("await start", sflag, 0);
  endtask : t_xfer
  task automatic t_cnt();
    dir <= 1'b0;
    sie <= 1'b0;
    do_reset();
    mode <= MODE_OFF;
    ssel <= 1'b1;
    cin <= 4'hf;
    cload <= 1'b1;
    @(posedge clk_i);
    cload <= 1'b0;
    ctl(3'b010);
    chk("edge ovf", oflag, 1);
    chk("irq masked", irq, 0);
    chk("strobe sel", sflag, 0);
    oie <= 1'b1;
    ssel <= 1'b0;
    ctl(3'b011);
    chk("edge flag", sflag, 1);
    chk("both edges", cnt, 1);
    chk("irq", irq, 1);
    chk("sticky", oflag, 1);
    oclr <= 1'b1;
    src <= CS_SOFT;
    strb <= 1'b1;
    @(posedge clk_i);
    oclr <= 1'b0;
    strb <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("cleared", oflag, 0);
    chk("strobe", cnt, 2);
  endtask : t_cnt
  // ==========================================================
  // run and watchdog
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    do_reset();
    t_regs();
    t_off();
    t_xfer();
    t_cnt();
    give_verdict();
  end
endmodule : ustwsd_test
`default_nettype wire
